// >>> hw/uareb_pkg.sv
// Types shared by the serial port design
package uareb_pkg;
  typedef enum logic [1:0] {
    UAREB_IDLE = 2'b00,
    UAREB_START = 2'b01,
    UAREB_DATA = 2'b11,
    UAREB_STOP = 2'b10
  } uareb_state_t;
  typedef struct packed {
    logic overrun;
    logic noise;
    logic framing;
    logic parity;
  } uareb_err_t;
endpackage : uareb_pkg

// >>> hw/uareb_top.sv
// Serial port with error interrupt control and shared data register
//
// Function
// - Overrun enable set requests interrupt while overrun flag is set.
// - Noise enable at bit 2 requests interrupt while noise flag set.
// - Framing enable at bit 1 requests interrupt while framing flag set.
// - Parity enable at bit 0 requests interrupt while parity flag set.
// - Data register read returns receive buffer, transmit buffer untouched.
// - Data register write loads transmit buffer, receive buffer untouched.
// - Data register read completes status flag clearing sequences.
// - Data bit n reads receive bit n and writes transmit bit n.
// - Full-duplex asynchronous NRZ link with matching framing and rate.
// - Transmitter and receiver run independently on one baud generator.
// - Baud generator runs from the bus clock.
// - New character while buffer full sets overrun and is discarded.
// - Buffer full flag clears by status read then data read.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "uarteb_defines.svh"
module uareb_top
  import uareb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Write address channel
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Serial line
  input wire logic rxd,
  output logic txd,
  // Error interrupt request
  output logic errIrq
);
  // Register state
  logic [7:0] errCtl_r;
  logic [7:0] txBuf_r;
  logic txFull_r;
  logic [7:0] rxBuf_r;
  logic rxFull_r;
  logic rxNinth_r;
  uareb_err_t errFlag_r;
  logic [12:0] baudDiv_r;
  logic [12:0] baudCnt_r;
  logic ovsTick;
  logic txEn_r;
  logic rxEn_r;
  logic parityEn_r;
  logic parityOdd_r;
  logic statusSeen_r;
  logic txBusy;
  logic txTake;

  // Bus handshake state
  logic [7:0] awAddr_r;
  logic awHave_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic wHave_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic wrFire;
  logic rdFire;

  // Address check shared by both paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `UAREB_ADDR_DATA) || (a == `UAREB_ADDR_ERRCTL) ||
      (a == `UAREB_ADDR_STATUS) || (a == `UAREB_ADDR_CTRL) ||
      (a == `UAREB_ADDR_BAUD);
  endfunction : addr_known

  assign s_axi_awready = !awHave_r && !bValid_r;
  assign s_axi_wready = !wHave_r && !bValid_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign wrFire = awHave_r && wHave_r && !bValid_r;
  assign rdFire = s_axi_arvalid && !rValid_r;

  // Write channel capture and response
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      awAddr_r <= 8'h00;
      awHave_r <= 1'b0;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      wHave_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `UAREB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (wrFire) begin
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
        bValid_r <= 1'b1;
        bResp_r <= addr_known(awAddr_r) ? `UAREB_RESP_OKAY : `UAREB_RESP_SLVERR;
      end else if (bValid_r && s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read channel with status, buffer and control views
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= `UAREB_RESP_OKAY;
    end else if (rdFire) begin
      rValid_r <= 1'b1;
      rResp_r <= addr_known(s_axi_araddr) ? `UAREB_RESP_OKAY : `UAREB_RESP_SLVERR;
      case (s_axi_araddr)
        `UAREB_ADDR_DATA: rData_r <= {24'h00_0000, rxBuf_r};
        `UAREB_ADDR_ERRCTL: rData_r <= {24'h00_0000, errCtl_r};
        `UAREB_ADDR_STATUS: rData_r <= {24'h00_0000, rxFull_r, !txFull_r,
          !txBusy && !txFull_r, errFlag_r, rxNinth_r};
        `UAREB_ADDR_CTRL: rData_r <= {28'h000_0000, parityOdd_r, parityEn_r,
          rxEn_r, txEn_r};
        `UAREB_ADDR_BAUD: rData_r <= {19'h0_0000, baudDiv_r};
        default: rData_r <= 32'h0000_0000;
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_r <= 1'b0;
    end
  end

  // Control registers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      errCtl_r <= `UAREB_ERRCTL_RST;
      baudDiv_r <= `UAREB_BAUD_RST;
      txEn_r <= 1'b0;
      rxEn_r <= 1'b0;
      parityEn_r <= 1'b0;
      parityOdd_r <= 1'b0;
    end else if (wrFire && wStrb_r[0]) begin
      case (awAddr_r)
        `UAREB_ADDR_ERRCTL: errCtl_r <= {4'h0, wData_r[3:0]};
        `UAREB_ADDR_CTRL: begin
          txEn_r <= wData_r[0];
          rxEn_r <= wData_r[1];
          parityEn_r <= wData_r[2];
          parityOdd_r <= wData_r[3];
        end
        `UAREB_ADDR_BAUD: baudDiv_r <= wData_r[12:0];
        default: begin
        end
      endcase
    end
  end

  // Shared 16x baud generator on the bus clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      baudCnt_r <= 13'h0000;
    end else if (ovsTick) begin
      baudCnt_r <= 13'h0000;
    end else begin
      baudCnt_r <= baudCnt_r + 13'h0001;
    end
  end
  assign ovsTick = (baudDiv_r <= 13'h0001) || (baudCnt_r >= baudDiv_r - 13'h0001);

  // Transmit buffer, filled by data register writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txBuf_r <= 8'h00;
      txFull_r <= 1'b0;
    end else if (wrFire && wStrb_r[0] && awAddr_r == `UAREB_ADDR_DATA) begin
      txBuf_r <= wData_r[7:0];
      txFull_r <= 1'b1;
    end else if (txTake) begin
      txFull_r <= 1'b0;
    end
  end

  uareb_tx u_tx (
    .clock(clock),
    .rstn(rstn),
    .ovsTick(ovsTick),
    .txEnable(txEn_r),
    .parityEn(parityEn_r),
    .parityOdd(parityOdd_r),
    .bufValid(txFull_r),
    .bufData(txBuf_r),
    .bufTake(txTake),
    .busy(txBusy),
    .txd(txd)
  );

  // Receive line synchroniser, three stages
  logic [2:0] rxSync_r;
  logic rxLevel_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxSync_r <= 3'b111;
      rxLevel_r <= 1'b1;
    end else begin
      rxSync_r <= {rxSync_r[1:0], rxd};
      if (rxSync_r[1] == rxSync_r[2]) begin
        rxLevel_r <= rxSync_r[2];
      end
    end
  end

  // Receiver, independent of the transmitter
  uareb_state_t rxState_r;
  logic [3:0] rxTick_r;
  logic [3:0] rxBit_r;
  logic [8:0] rxShift_r;
  logic rxNoise_r;
  logic rxDone;
  logic rxFrameOk;
  logic [2:0] rxVote_r;
  assign rxDone = ovsTick && rxState_r == UAREB_STOP && rxTick_r == 4'h0;
  assign rxFrameOk = rxLevel_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxState_r <= UAREB_IDLE;
      rxTick_r <= 4'h0;
      rxBit_r <= 4'h0;
      rxShift_r <= 9'h000;
      rxNoise_r <= 1'b0;
      rxVote_r <= 3'b000;
    end else if (ovsTick) begin
      rxTick_r <= rxTick_r + 4'h1;
      rxVote_r <= {rxVote_r[1:0], rxLevel_r};
      case (rxState_r)
        UAREB_IDLE: begin
          rxTick_r <= 4'h0;
          rxNoise_r <= 1'b0;
          if (rxEn_r && !rxLevel_r) begin
            rxState_r <= UAREB_START;
          end
        end
        UAREB_START: begin
          if (rxTick_r == `UAREB_OVS_HALF) begin
            if (rxLevel_r) begin
              rxState_r <= UAREB_IDLE;
            end else begin
              rxState_r <= UAREB_DATA;
              rxTick_r <= 4'h1;
              rxBit_r <= 4'h0;
            end
          end
        end
        UAREB_DATA: begin
          if (rxTick_r == 4'h0) begin
            rxShift_r <= {rxLevel_r, rxShift_r[8:1]};
            if (rxVote_r[0] != rxLevel_r || rxVote_r[1] != rxLevel_r) begin
              rxNoise_r <= 1'b1;
            end
            if (rxBit_r == (parityEn_r ? 4'h8 : 4'h7)) begin
              rxState_r <= UAREB_STOP;
            end
            rxBit_r <= rxBit_r + 4'h1;
          end
        end
        UAREB_STOP: begin
          if (rxTick_r == 4'h0) begin
            rxState_r <= UAREB_IDLE;
          end
        end
        default: begin
          rxState_r <= UAREB_IDLE;
        end
      endcase
    end
  end

  // Status read arms the clear; data register read completes it
  logic statusRd;
  logic dataRd;
  logic [7:0] rxByte;
  logic rxPar;
  assign statusRd = rdFire && s_axi_araddr == `UAREB_ADDR_STATUS;
  assign dataRd = rdFire && s_axi_araddr == `UAREB_ADDR_DATA;
  assign rxByte = parityEn_r ? rxShift_r[7:0] : rxShift_r[8:1];
  assign rxPar = parityEn_r && ((^rxShift_r) ^ parityOdd_r);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      statusSeen_r <= 1'b0;
    end else if (statusRd && (rxFull_r || (|errFlag_r))) begin
      statusSeen_r <= 1'b1;
    end else if (dataRd) begin
      statusSeen_r <= 1'b0;
    end
  end

  // Receive buffer and flags; a new event wins over a clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxBuf_r <= 8'h00;
      rxFull_r <= 1'b0;
      rxNinth_r <= 1'b0;
      errFlag_r <= '0;
    end else begin
      if (dataRd && statusSeen_r) begin
        rxFull_r <= 1'b0;
        errFlag_r <= '0;
      end
      if (rxDone) begin
        if (rxFull_r && !(dataRd && statusSeen_r)) begin
          errFlag_r.overrun <= 1'b1;
        end else begin
          rxBuf_r <= rxByte;
          rxNinth_r <= rxShift_r[8];
          rxFull_r <= 1'b1;
          errFlag_r.noise <= rxNoise_r;
          errFlag_r.framing <= !rxFrameOk;
          errFlag_r.parity <= rxPar;
        end
      end
    end
  end

  // Gated error request
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      errIrq <= 1'b0;
    end else begin
      errIrq <= (errFlag_r.overrun && errCtl_r[`UAREB_BIT_OVERRUN_IE]) ||
        (errFlag_r.noise && errCtl_r[`UAREB_BIT_NOISE_IE]) ||
        (errFlag_r.framing && errCtl_r[`UAREB_BIT_FRAMING_IE]) ||
        (errFlag_r.parity && errCtl_r[`UAREB_BIT_PARITY_IE]);
    end
  end
endmodule : uareb_top

// >>> hw/uareb_tx.sv
// Transmit shifter for the serial port
`timescale 1ns/100ps
`include "uarteb_defines.svh"
module uareb_tx
  import uareb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Bit timing
  input wire logic ovsTick,
  input wire logic txEnable,
  input wire logic parityEn,
  input wire logic parityOdd,
  // Buffer side
  input wire logic bufValid,
  input wire logic [7:0] bufData,
  output logic bufTake,
  output logic busy,
  // Line
  output logic txd
);
  uareb_state_t state_r;
  logic [3:0] tick_r;
  logic [3:0] bitIdx_r;
  logic [8:0] shift_r;
  logic txd_r;

  assign bufTake = (state_r == UAREB_IDLE) && txEnable && bufValid && ovsTick;
  assign busy = (state_r != UAREB_IDLE);
  assign txd = txd_r;

  // Bit shifter on the shared 16x tick
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= UAREB_IDLE;
      tick_r <= 4'h0;
      bitIdx_r <= 4'h0;
      shift_r <= 9'h000;
      txd_r <= 1'b1;
    end else if (ovsTick) begin
      tick_r <= tick_r + 4'h1;
      case (state_r)
        UAREB_IDLE: begin
          txd_r <= 1'b1;
          tick_r <= 4'h0;
          if (bufTake) begin
            shift_r <= {(^bufData) ^ parityOdd, bufData};
            state_r <= UAREB_START;
            txd_r <= 1'b0;
          end
        end
        UAREB_START: begin
          if (tick_r == 4'hF) begin
            state_r <= UAREB_DATA;
            bitIdx_r <= 4'h0;
            txd_r <= shift_r[0];
          end
        end
        UAREB_DATA: begin
          if (tick_r == 4'hF) begin
            if (bitIdx_r == (parityEn ? 4'h8 : 4'h7)) begin
              state_r <= UAREB_STOP;
              txd_r <= 1'b1;
            end else begin
              bitIdx_r <= bitIdx_r + 4'h1;
              shift_r <= {1'b0, shift_r[8:1]};
              txd_r <= shift_r[1];
            end
          end
        end
        UAREB_STOP: begin
          if (tick_r == 4'hF) begin
            state_r <= UAREB_IDLE;
          end
        end
        default: begin
          state_r <= UAREB_IDLE;
        end
      endcase
    end
  end
endmodule : uareb_tx

// >>> hw/uarteb_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UAREB_DEFINES_SVH
`define UAREB_DEFINES_SVH
`define UAREB_OFF_DATA_IDX 4'h7
`define UAREB_ADDR_DATA 8'h1C
`define UAREB_ADDR_ERRCTL 8'h20
`define UAREB_ADDR_STATUS 8'h24
`define UAREB_ADDR_CTRL 8'h28
`define UAREB_ADDR_BAUD 8'h2C
`define UAREB_BIT_PARITY_IE 0
`define UAREB_BIT_FRAMING_IE 1
`define UAREB_BIT_NOISE_IE 2
`define UAREB_BIT_OVERRUN_IE 3
`define UAREB_ERRCTL_RST 8'h00
`define UAREB_BAUD_RST 13'h0004
`define UAREB_OVS 5'h10
`define UAREB_OVS_HALF 4'h8
`define UAREB_RESP_OKAY 2'b00
`define UAREB_RESP_SLVERR 2'b10
`endif

// >>> tb/testbench.sv
// Self-checking bench for the serial port
`timescale 1ns/100ps
`include "uarteb_defines.svh"
module testbench;
  logic clock, rstn, rxd, txd, errIrq, gotValid;
  logic [7:0] s_axi_awaddr, s_axi_araddr, gotData, t, u;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] txq[$];
  logic [15:0] lfsr;
  int n_errors, comparisons, i, k;
  uareb_top uut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxd, .txd, .errIrq);
  uareb_remote remote (.clock, .rxd, .txd, .gotValid, .gotData);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic finish_test();
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_errors++;
      finish_test();
    end
  endtask : tmo
  function automatic logic [7:0] nextByte();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : nextByte
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    logic awT, wT, bv, done;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge clock);
      awT = s_axi_awvalid && s_axi_awready;
      wT = s_axi_wvalid && s_axi_wready;
      bv = s_axi_bvalid;
      done = bv && s_axi_bready;
      @(posedge clock);
      if (awT) s_axi_awvalid <= 1'b0;
      if (wT) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !done;
    end
    tmo(done ? 0 : n, 100);
  endtask : axiWrite
  task automatic axiRead(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                         input logic [1:0] r);
    int n;
    logic arT, rv, done;
    rq.push_back({r, m, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    done = 1'b0;
    for (n = 0; n < 100 && !done; n++) begin
      @(negedge clock);
      arT = s_axi_arvalid && s_axi_arready;
      rv = s_axi_rvalid;
      done = rv && s_axi_rready;
      @(posedge clock);
      if (arT) s_axi_arvalid <= 1'b0;
      s_axi_rready <= rv && !done;
    end
    tmo(done ? 0 : n, 100);
  endtask : axiRead
  task automatic chkIrq(input logic e);
    @(negedge clock);
    chk({31'h0, errIrq}, {31'h0, e});
    @(posedge clock);
  endtask : chkIrq
  // Result watcher, on settled values
  always @(negedge clock) begin
    logic [65:0] en;
    if (s_axi_rvalid && s_axi_rready) begin
      en = rq.pop_front();
      chk(s_axi_rdata & en[63:32], en[31:0] & en[63:32]);
      chk({30'h0, s_axi_rresp}, {30'h0, en[65:64]});
    end
    if (s_axi_bvalid && s_axi_bready) chk({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    if (gotValid) chk({24'h00_0000, gotData}, {24'h00_0000, txq.pop_front()});
  end
  initial begin
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0000_0000_0000;
    s_axi_wstrb = 4'hF;
    lfsr = 16'hFDC7;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    axiRead(`UAREB_ADDR_ERRCTL, 32'h0000_0000, 32'h0000_00FF, `UAREB_RESP_OKAY);
    axiRead(`UAREB_ADDR_BAUD, 32'h0000_0004, 32'h0000_1FFF, `UAREB_RESP_OKAY);
    axiWrite(`UAREB_ADDR_BAUD, 32'h0000_0001, `UAREB_RESP_OKAY);
    axiWrite(8'h30, 32'hFFFF_FFFF, `UAREB_RESP_SLVERR);
    axiRead(8'h30, 32'h0000_0000, 32'hFFFF_FFFF, `UAREB_RESP_SLVERR);
    axiWrite(`UAREB_ADDR_CTRL, 32'h0000_0003, `UAREB_RESP_OKAY);
    for (k = 0; k < 3; k++) begin
      t = nextByte();
      u = nextByte();
      txq.push_back(t);
      fork
        axiWrite(`UAREB_ADDR_DATA, {24'h00_0000, t}, `UAREB_RESP_OKAY);
        remote.sendChar(u, 1'b0, 1'b0, 1'b1, 1'b0);
      join
      axiRead(`UAREB_ADDR_DATA, {24'h00_0000, u}, 32'hFFFF_FFFF, `UAREB_RESP_OKAY);
      axiRead(`UAREB_ADDR_STATUS, 32'h0000_0080, 32'h0000_0080, `UAREB_RESP_OKAY);
      axiRead(`UAREB_ADDR_DATA, {24'h00_0000, u}, 32'hFFFF_FFFF, `UAREB_RESP_OKAY);
      axiRead(`UAREB_ADDR_STATUS, 32'h0000_0000, 32'h0000_0080, `UAREB_RESP_OKAY);
      for (i = 0; i < 400 && txq.size() != 0; i++) @(posedge clock);
      tmo(i, 400);
    end
    // Parity, framing, noise, overrun in enable bit order
    for (k = 0; k < 4; k++) begin
      axiWrite(`UAREB_ADDR_CTRL, k == 0 ? 32'h0000_0007 : 32'h0000_0003, `UAREB_RESP_OKAY);
      axiWrite(`UAREB_ADDR_ERRCTL, 32'h0000_000F ^ (32'h1 << k), `UAREB_RESP_OKAY);
      remote.sendChar(k == 3 ? 8'h11 : k == 2 ? 8'hFF : 8'h3C, k == 0, 1'b1, k != 1, k == 2);
      if (k == 3) remote.sendChar(8'h22, 1'b0, 1'b0, 1'b1, 1'b0);
      chkIrq(1'b0);
      axiWrite(`UAREB_ADDR_ERRCTL, 32'h1 << k, `UAREB_RESP_OKAY);
      chkIrq(1'b1);
      axiRead(`UAREB_ADDR_STATUS, 32'h2 << k, 32'h2 << k, `UAREB_RESP_OKAY);
      axiRead(`UAREB_ADDR_DATA, 32'h0000_0011, k == 3 ? 32'hFF : 32'h0, `UAREB_RESP_OKAY);
      chkIrq(1'b0);
    end
    chk(32'(txq.size() + rq.size() + bq.size()), 32'h0000_0000);
    finish_test();
  end
endmodule : testbench
bind uareb_top uareb_checker chk (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .errIrq);

// >>> tb/uareb_remote.sv
// Remote serial station model
`timescale 1ns/100ps
module uareb_remote #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic clock,
  // Line
  output logic rxd,
  input wire logic txd,
  // Decoded characters
  output logic gotValid,
  output logic [7:0] gotData
);
  logic [7:0] sh;
  initial rxd = 1'b1;
  // Sender, ends on one idle bit
  task automatic sendChar(input logic [7:0] d, input logic parOn, input logic parBit,
                          input logic stopBit, input logic glitch);
    logic [11:0] f;
    f = parOn ? {1'b1, stopBit, parBit, d, 1'b0} : {2'b11, stopBit, d, 1'b0};
    for (int i = 0; i < (parOn ? 12 : 11); i++) begin
      for (int c = 0; c < BIT; c++) begin
        rxd <= (glitch && i == 4 && (c == 8 || c == 9)) ? !f[i] : f[i];
        @(posedge clock);
      end
    end
  endtask : sendChar
  // Decoder, samples mid-bit
  initial begin
    gotValid = 1'b0;
    gotData = 8'h00;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clock);
        sh[i] = txd;
      end
      repeat (BIT) @(posedge clock);
      if (txd) begin
        gotData <= sh;
        gotValid <= 1'b1;
        @(posedge clock);
        gotValid <= 1'b0;
      end
    end
  end
endmodule : uareb_remote

// >>> tb/uareb_top_assertions.sv
// Port checker for the serial port
`timescale 1ns/100ps
module uareb_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line and interrupt
  input wire logic rxd,
  input wire logic txd,
  input wire logic errIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wrBoth;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read not answered");
  a_data_width: assert property (rdTaken ##0 s_axi_araddr == 8'h1C |=>
    s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rresp == 2'b00) else $error("data word bad");
  a_write_answer: assert property (wrBoth |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_irq_reset: assert property ($rose(rstn) |-> !errIrq [*2])
    else $error("interrupt after reset");
endmodule : uareb_checker
